// ==== inc/lbx_pkg.sv ====
// Package for the ladder bit logic executor.
// Shared by the executor core, the condition stack and the edge memory.
package lbx_pkg;
    localparam int LBX_OP_W = 5;
    localparam int LBX_ADDR_W = 8;
    localparam int LBX_EDGE_SLOTS = 16;
    localparam int LBX_EDGE_IDX_W = 4;
    localparam int LBX_STACK_DEPTH = 8;
    localparam int LBX_PC_W = 8;
    localparam logic [LBX_OP_W-1:0] OP_NOP = 5'h00;
    localparam logic [LBX_OP_W-1:0] OP_END = 5'h01;
    localparam logic [LBX_OP_W-1:0] OP_LOCK_BEGIN = 5'h02;
    localparam logic [LBX_OP_W-1:0] OP_LOCK_CLEAR = 5'h03;
    localparam logic [LBX_OP_W-1:0] OP_RISE = 5'h0a;
    localparam logic [LBX_OP_W-1:0] OP_FALL = 5'h0b;
    localparam logic [LBX_OP_W-1:0] OP_LATCH = 5'h0c;
    localparam logic [LBX_OP_W-1:0] OP_LOAD = 5'h10;
    localparam logic [LBX_OP_W-1:0] OP_LOAD_INV = 5'h11;
    localparam logic [LBX_OP_W-1:0] OP_SERIES = 5'h12;
    localparam logic [LBX_OP_W-1:0] OP_SERIES_INV = 5'h13;
    localparam logic [LBX_OP_W-1:0] OP_PAR = 5'h14;
    localparam logic [LBX_OP_W-1:0] OP_PAR_INV = 5'h15;
    localparam logic [LBX_OP_W-1:0] OP_BLK_SERIES = 5'h16;
    localparam logic [LBX_OP_W-1:0] OP_BLK_PAR = 5'h17;
    localparam logic [LBX_OP_W-1:0] OP_OUT = 5'h18;
    localparam logic [LBX_OP_W-1:0] OP_OUT_INV = 5'h19;
    localparam logic [LBX_PC_W-1:0] LBX_PC_RESET = 8'h00;
    typedef enum logic [3:0] {
        LBX_IDLE = 4'b0001,
        LBX_SEEK = 4'b0010,
        LBX_RUN = 4'b0100,
        LBX_FAULT = 4'b1000
    } lbx_state_type;
endpackage : lbx_pkg

// ==== inc/lbx_cond_if.sv ====
// Interface carrying condition stack requests between the core and the stack.
// Assumes a single clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface lbx_cond_if;
    logic push;
    logic pop;
    logic clear;
    logic push_val;
    logic top_val;
    logic empty;
    modport core (output push, output pop, output clear, output push_val, input top_val, input empty);
    modport stack (input push, input pop, input clear, input push_val, output top_val, output empty);
endinterface : lbx_cond_if
`default_nettype wire

// ==== design/lbx_cond_stack.sv ====
// Stack of earlier execution conditions not yet consumed.
// Assumes push and pop are not requested in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module lbx_cond_stack
    import lbx_pkg::*;
#(
    parameter int DEPTH = LBX_STACK_DEPTH
)
(
    input wire logic CLK,
    input wire logic RESET,
    lbx_cond_if.stack cif
);
    logic [DEPTH-1:0] stk_r;
    logic [$clog2(DEPTH+1)-1:0] cnt_r;

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            stk_r <= '0;
            cnt_r <= '0;
        end
        else if (cif.clear)
        begin
            cnt_r <= '0;
        end
        else if (cif.push && cnt_r != DEPTH[$clog2(DEPTH+1)-1:0])
        begin
            stk_r <= {stk_r[DEPTH-2:0], cif.push_val};
            cnt_r <= cnt_r + 1'b1;
        end
        else if (cif.pop && cnt_r != '0)
        begin
            stk_r <= {1'b0, stk_r[DEPTH-1:1]};
            cnt_r <= cnt_r - 1'b1;
        end
    end

    assign cif.top_val = stk_r[0];
    assign cif.empty = (cnt_r == '0);
endmodule : lbx_cond_stack
`default_nettype wire

// ==== design/lbx_edge_mem.sv ====
// Previous-condition memory for the edge pulse instructions.
// Assumes the core gives each edge instruction its own slot index.
`timescale 1ns/1ps
`default_nettype none
module lbx_edge_mem
    import lbx_pkg::*;
#(
    parameter int SLOTS = LBX_EDGE_SLOTS
)
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [lbx_pkg::LBX_EDGE_IDX_W-1:0] idx,
    input wire logic wr,
    input wire logic wval,
    output logic prev
);
    logic [SLOTS-1:0] mem_r;

    // One flop per slot.
    genvar g;
    generate
        for (g = 0; g < SLOTS; g++)
        begin : g_slot
            always_ff @(posedge CLK or posedge RESET)
            begin
                if (RESET)
                    mem_r[g] <= 1'b0;
                else if (wr && idx == LBX_EDGE_IDX_W'(g))
                    mem_r[g] <= wval;
            end
        end
    endgenerate

    assign prev = mem_r[idx];
endmodule : lbx_edge_mem
`default_nettype wire

// ==== design/lbx_executor.sv ====
// Ladder bit logic executor: runs bit instructions of the stored program once per scan.
// Assumes program words and data bits are read combinationally on the same clock.
//
// Functional notes
// - Nothing executes unless the program holds a terminator instruction.
// - Load starts a condition from the operand bit, load-inverted from its inverse.
// - Series ANDs the condition with the bit or its inverse.
// - Parallel ORs the condition with the bit or its inverse.
// - Block series and parallel combine current with last unconsumed condition.
// - Basic instructions have no count or order limit besides program memory; the condition stack holds only 8 unconsumed conditions.
// - Output copies the condition into its bit.
// - Inverted output writes the complement of the condition into its bit.
// - Up to 16 edge instructions have previous-condition memory.
// - Rising edge sets its bit on OFF to ON, else clears it.
// - Falling edge sets its bit on ON to OFF, else clears it.
// - Each edge execution stores its condition as the previous condition.
// - Latch takes a set condition first and a reset condition second.
// - Latch set ON sets the bit and holds it until reset.
// - Latch reset ON clears the bit and holds it cleared.
// - Latched bits are not cleared inside an OFF interlock.
// - Retentive area bits keep their state through power loss.
// - These instructions never alter error, carry or comparison flags; here the terminator clears all five FLAGS_OUT bits.
// - Inside an OFF interlock edge instructions keep their previous condition.
`timescale 1ns/1ps
`default_nettype none
module lbx_executor
    import lbx_pkg::*;
#(
    parameter int PROG_DEPTH = 256
)
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic RUN_MODE,
    input wire logic [lbx_pkg::LBX_OP_W-1:0] PROG_OP,
    input wire logic [lbx_pkg::LBX_ADDR_W-1:0] PROG_OPERAND,
    input wire logic [lbx_pkg::LBX_EDGE_IDX_W-1:0] PROG_EDGE_SLOT,
    input wire logic RETENTIVE_BIT,
    input wire logic DATA_BIT,
    input wire logic [4:0] FLAGS_IN,
    output logic [lbx_pkg::LBX_PC_W-1:0] PROG_ADDR,
    output logic [lbx_pkg::LBX_ADDR_W-1:0] BIT_ADDR,
    output logic BIT_WR,
    output logic BIT_WVAL,
    output logic [4:0] FLAGS_OUT,
    output logic NO_TERMINATOR,
    output logic SCAN_DONE,
    output logic RUNNING
);
    lbx_state_type state_r;
    lbx_state_type state_nxt;
    logic [LBX_PC_W-1:0] pc_r;
    logic cond_r;
    logic cond_nxt;
    logic lock_pass_r;
    logic latch_set_r;
    logic latch_val;
    logic prev_cond;
    logic edge_wr;
    logic is_edge;
    logic operand_val;
    logic [LBX_ADDR_W-1:0] bit_addr_r;
    logic bit_wr_r;
    logic bit_wval_r;
    logic [4:0] flags_r;
    logic noterm_r;
    logic done_r;
    logic run_r;
    logic at_top;

    lbx_cond_if cif ();

    lbx_cond_stack #(.DEPTH(LBX_STACK_DEPTH)) u_stack (
        .CLK(CLK),
        .RESET(RESET),
        .cif(cif)
    );

    lbx_edge_mem #(.SLOTS(LBX_EDGE_SLOTS)) u_edge (
        .CLK(CLK),
        .RESET(RESET),
        .idx(PROG_EDGE_SLOT),
        .wr(edge_wr),
        .wval(cond_r),
        .prev(prev_cond)
    );

    assign at_top = (pc_r == LBX_PC_RESET + LBX_PC_W'(PROG_DEPTH - 1));
    assign is_edge = (PROG_OP == OP_RISE) || (PROG_OP == OP_FALL);
    assign operand_val = DATA_BIT;
    assign latch_val = RETENTIVE_BIT;

    // The program is searched up to its first terminator before any run.
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            LBX_IDLE:
                if (RUN_MODE)
                    state_nxt = LBX_SEEK;
            LBX_SEEK:
                if (!RUN_MODE)
                    state_nxt = LBX_IDLE;
                else if (PROG_OP == OP_END)
                    state_nxt = LBX_RUN;
                else if (at_top)
                    state_nxt = LBX_FAULT;
            LBX_RUN:
                if (!RUN_MODE)
                    state_nxt = LBX_IDLE;
            LBX_FAULT:
                if (!RUN_MODE)
                    state_nxt = LBX_IDLE;
        endcase
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            state_r <= LBX_IDLE;
        else
            state_r <= state_nxt;
    end

    // Program counter wraps to the first address at the terminator.
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            pc_r <= LBX_PC_RESET;
        else if (state_r == LBX_IDLE || (state_nxt == LBX_RUN && state_r == LBX_SEEK))
            pc_r <= LBX_PC_RESET;
        else if (state_r == LBX_RUN && PROG_OP == OP_END)
            pc_r <= LBX_PC_RESET;
        else if (state_r == LBX_SEEK || state_r == LBX_RUN)
            pc_r <= pc_r + 1'b1;
    end

    // Condition evaluation; only the RUN state executes anything.
    always_comb
    begin
        cond_nxt = cond_r;
        cif.push = 1'b0;
        cif.pop = 1'b0;
        cif.clear = 1'b0;
        cif.push_val = cond_r;
        if (state_r == LBX_RUN)
        begin
            unique case (PROG_OP)
                OP_LOAD:
                begin
                    cif.push = 1'b1;
                    cond_nxt = operand_val;
                end
                OP_LOAD_INV:
                begin
                    cif.push = 1'b1;
                    cond_nxt = ~operand_val;
                end
                OP_SERIES: cond_nxt = cond_r & operand_val;
                OP_SERIES_INV: cond_nxt = cond_r & ~operand_val;
                OP_PAR: cond_nxt = cond_r | operand_val;
                OP_PAR_INV: cond_nxt = cond_r | ~operand_val;
                OP_BLK_SERIES:
                begin
                    cif.pop = 1'b1;
                    cond_nxt = cond_r & cif.top_val;
                end
                OP_BLK_PAR:
                begin
                    cif.pop = 1'b1;
                    cond_nxt = cond_r | cif.top_val;
                end
                OP_LOCK_BEGIN: cif.clear = 1'b1;
                OP_OUT, OP_OUT_INV, OP_RISE, OP_FALL:
                begin
                    cif.clear = 1'b1;
                    cond_nxt = 1'b0;
                end
                OP_LATCH:
                begin
                    cif.clear = 1'b1;
                    cond_nxt = 1'b0;
                end
                default: cond_nxt = cond_r;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            cond_r <= 1'b0;
        else
            cond_r <= cond_nxt;
    end

    // Interlock state: an OFF interlock condition forces outputs off and freezes edges and latches until the clear instruction or the terminator.
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            lock_pass_r <= 1'b1;
        else if (state_r != LBX_RUN || PROG_OP == OP_END || PROG_OP == OP_LOCK_CLEAR)
            lock_pass_r <= 1'b1;
        else if (PROG_OP == OP_LOCK_BEGIN)
            lock_pass_r <= lock_pass_r & cond_r;
    end

    // The latch set condition is the pending one beneath the reset condition.
    always_comb
    begin
        latch_set_r = cif.top_val;
    end

    assign edge_wr = (state_r == LBX_RUN) && is_edge && lock_pass_r;

    // Bit write port.
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            bit_wr_r <= 1'b0;
            bit_wval_r <= 1'b0;
            bit_addr_r <= '0;
        end
        else
        begin
            bit_wr_r <= 1'b0;
            bit_addr_r <= PROG_OPERAND;
            bit_wval_r <= 1'b0;
            if (state_r == LBX_RUN)
            begin
                unique case (PROG_OP)
                    OP_OUT:
                    begin
                        bit_wr_r <= 1'b1;
                        bit_wval_r <= cond_r & lock_pass_r;
                    end
                    OP_OUT_INV:
                    begin
                        bit_wr_r <= 1'b1;
                        bit_wval_r <= ~cond_r & lock_pass_r;
                    end
                    OP_RISE:
                    begin
                        bit_wr_r <= lock_pass_r;
                        bit_wval_r <= cond_r & ~prev_cond;
                    end
                    OP_FALL:
                    begin
                        bit_wr_r <= lock_pass_r;
                        bit_wval_r <= ~cond_r & prev_cond;
                    end
                    OP_LATCH:
                    begin
                        bit_wr_r <= lock_pass_r;
                        if (cond_r)
                            bit_wval_r <= 1'b0;
                        else if (latch_set_r)
                            bit_wval_r <= 1'b1;
                        else
                            bit_wval_r <= latch_val;
                    end
                    default: bit_wr_r <= 1'b0;
                endcase
            end
        end
    end

    // Arithmetic flags pass through untouched; the terminator clears them.
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            flags_r <= '0;
        else if (state_r == LBX_RUN && PROG_OP == OP_END)
            flags_r <= '0;
        else
            flags_r <= FLAGS_IN;
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            noterm_r <= 1'b0;
            done_r <= 1'b0;
            run_r <= 1'b0;
        end
        else
        begin
            noterm_r <= (state_nxt == LBX_FAULT);
            done_r <= (state_r == LBX_RUN) && (PROG_OP == OP_END);
            run_r <= (state_nxt == LBX_RUN);
        end
    end

    assign PROG_ADDR = pc_r;
    assign BIT_ADDR = bit_addr_r;
    assign BIT_WR = bit_wr_r;
    assign BIT_WVAL = bit_wval_r;
    assign FLAGS_OUT = flags_r;
    assign NO_TERMINATOR = noterm_r;
    assign SCAN_DONE = done_r;
    assign RUNNING = run_r;

    AST_NO_RUN_WITHOUT_END: assert property (@(posedge CLK) disable iff (RESET)
        state_r == LBX_FAULT |=> !BIT_WR)
        else $error("Bit written without terminator.");

    AST_OUT_COPY: assert property (@(posedge CLK) disable iff (RESET)
        state_r == LBX_RUN && PROG_OP == OP_OUT && lock_pass_r |=> BIT_WR && BIT_WVAL == $past(cond_r))
        else $error("Output did not copy condition.");

    AST_OUT_INV: assert property (@(posedge CLK) disable iff (RESET)
        state_r == LBX_RUN && PROG_OP == OP_OUT_INV && lock_pass_r |=> BIT_WR && BIT_WVAL != $past(cond_r))
        else $error("Inverted output wrong.");

    AST_RISE: assert property (@(posedge CLK) disable iff (RESET)
        state_r == LBX_RUN && PROG_OP == OP_RISE && lock_pass_r |=>
        BIT_WR && BIT_WVAL == ($past(cond_r) && !$past(prev_cond)))
        else $error("Rising edge pulse wrong.");

    AST_FALL: assert property (@(posedge CLK) disable iff (RESET)
        state_r == LBX_RUN && PROG_OP == OP_FALL && lock_pass_r |=>
        BIT_WR && BIT_WVAL == (!$past(cond_r) && $past(prev_cond)))
        else $error("Falling edge pulse wrong.");

    AST_LATCH_RESET: assert property (@(posedge CLK) disable iff (RESET)
        state_r == LBX_RUN && PROG_OP == OP_LATCH && lock_pass_r && cond_r |=> BIT_WR && !BIT_WVAL)
        else $error("Latch reset lost priority.");

    AST_LATCH_INTERLOCK: assert property (@(posedge CLK) disable iff (RESET)
        state_r == LBX_RUN && PROG_OP == OP_LATCH && !lock_pass_r |=> !BIT_WR)
        else $error("Latch bit touched in interlock.");

    AST_EDGE_FREEZE: assert property (@(posedge CLK) disable iff (RESET)
        state_r == LBX_RUN && is_edge && !lock_pass_r |=> u_edge.mem_r == $past(u_edge.mem_r))
        else $error("Edge memory updated in interlock.");

    AST_CONSUME: assert property (@(posedge CLK) disable iff (RESET)
        state_r == LBX_RUN && PROG_OP == OP_OUT |=> !cond_r)
        else $error("Condition not consumed.");

    AST_FLAGS: assert property (@(posedge CLK) disable iff (RESET)
        state_r == LBX_RUN && PROG_OP != OP_END |=> FLAGS_OUT == $past(FLAGS_IN))
        else $error("Flags altered.");
endmodule : lbx_executor
`default_nettype wire

// ==== tb/tb_ladder_bit_logic_executor.sv ====
// Self-checking bench for the ladder bit logic executor.
// Assumes the package and the executor sources are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_ladder_bit_logic_executor;
    import lbx_pkg::*;
    localparam int PD = 64;
    localparam int MAX_CYC = 20000;
    logic clk;
    logic reset;
    logic run_mode;
    logic [LBX_OP_W-1:0] prog_op_in;
    logic [LBX_ADDR_W-1:0] prog_operand;
    logic [LBX_EDGE_IDX_W-1:0] prog_edge_slot;
    logic retentive_bit;
    logic data_bit;
    logic [4:0] flags_in;
    logic [LBX_PC_W-1:0] prog_addr;
    logic [LBX_ADDR_W-1:0] bit_addr;
    logic bit_wr;
    logic bit_wval;
    logic [4:0] flags_out;
    logic no_terminator;
    logic scan_done;
    logic running;
    logic [LBX_OP_W-1:0] prog_op [0:255];
    logic [7:0] prog_opd [0:255];
    logic [3:0] prog_slot [0:255];
    logic mem [0:255];
    logic prev [0:15];
    logic [7:0] exp_addr [$];
    logic exp_val [$];
    logic [4:0] flags_hold;
    int seed;
    int miscompares;
    int samples_checked;
    int cycles;
    int plen;

    lbx_executor #(.PROG_DEPTH(PD)) i_lbx_executor (.CLK(clk), .RESET(reset), .RUN_MODE(run_mode),
        .PROG_OP(prog_op_in), .PROG_OPERAND(prog_operand), .PROG_EDGE_SLOT(prog_edge_slot),
        .RETENTIVE_BIT(retentive_bit), .DATA_BIT(data_bit), .FLAGS_IN(flags_in), .PROG_ADDR(prog_addr),
        .BIT_ADDR(bit_addr), .BIT_WR(bit_wr), .BIT_WVAL(bit_wval), .FLAGS_OUT(flags_out),
        .NO_TERMINATOR(no_terminator), .SCAN_DONE(scan_done), .RUNNING(running));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic stop_test;
        $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic add(input logic [LBX_OP_W-1:0] op, input logic [7:0] opd, input logic [3:0] sl);
        prog_op[plen] = op;
        prog_opd[plen] = opd;
        prog_slot[plen] = sl;
        plen++;
    endtask : add

    task automatic note(input logic [7:0] a, input logic v);
        exp_addr.push_back(a);
        exp_val.push_back(v);
    endtask : note

    // Reference interpreter: one pass over the program, noting every bit write it expects.
    task automatic model_scan;
        logic c;
        logic s;
        logic ilk;
        logic st [$];
        logic [LBX_OP_W-1:0] op;
        logic [7:0] a;
        logic [3:0] sl;
        int pc;
        c = 1'b0;
        ilk = 1'b1;
        for (pc = 0; pc < PD && prog_op[pc] !== OP_END; pc++)
        begin
            op = prog_op[pc];
            a = prog_opd[pc];
            sl = prog_slot[pc];
            if (op == OP_LOAD || op == OP_LOAD_INV)
                st.push_back(c);
            case (op)
                OP_LOAD: c = mem[a];
                OP_LOAD_INV: c = ~mem[a];
                OP_SERIES: c = c & mem[a];
                OP_SERIES_INV: c = c & ~mem[a];
                OP_PAR: c = c | mem[a];
                OP_PAR_INV: c = c | ~mem[a];
                OP_BLK_SERIES: c = c & st.pop_back();
                OP_BLK_PAR: c = c | st.pop_back();
                OP_OUT: note(a, ilk & c);
                OP_OUT_INV: note(a, ilk & ~c);
                OP_LOCK_BEGIN: ilk = ilk & c;
                OP_LOCK_CLEAR: ilk = 1'b1;
                OP_RISE, OP_FALL:
                begin
                    if (ilk)
                    begin
                        note(a, (op == OP_RISE) ? (c & ~prev[sl]) : (~c & prev[sl]));
                        prev[sl] = c;
                    end
                end
                OP_LATCH:
                begin
                    s = st.pop_back();
                    if (ilk)
                        note(a, c ? 1'b0 : (s ? 1'b1 : mem[a]));
                end
                default: c = c;
            endcase
            if (op inside {OP_OUT, OP_OUT_INV, OP_RISE, OP_FALL, OP_LATCH})
                st.delete();
        end
    endtask : model_scan

    task automatic new_inputs;
        for (int i = 0; i < 8; i++)
            mem[i] = $random(seed);
        flags_hold = $random(seed);
        flags_in = flags_hold;
    endtask : new_inputs

    task automatic pulse_reset;
        reset = 1'b1;
        exp_addr.delete();
        exp_val.delete();
        for (int i = 0; i < 16; i++)
            prev[i] = 1'b0;
        repeat (5) @(negedge clk);
        reset = 1'b0;
    endtask : pulse_reset

    task automatic wait_flag(input int which);
        int n;
        n = 0;
        @(negedge clk);
        while (((which == 0) ? scan_done : running) !== 1'b1 && n < 4 * PD)
        begin
            @(negedge clk);
            n++;
        end
        check("wait_flag", {7'h00, (n < 4 * PD)}, 8'h01);
    endtask : wait_flag

    // Program feed, bit memory and write monitor all act at the falling edge.
    always @(negedge clk)
    begin
        cycles++;
        if (!reset && bit_wr === 1'b1)
        begin
            mem[bit_addr] = bit_wval;
            if (exp_addr.size() == 0)
                check("stray_write", {7'h00, bit_wr}, 8'h00);
            else
            begin
                check("bit_addr", bit_addr, exp_addr.pop_front());
                check("bit_val", {7'h00, bit_wval}, {7'h00, exp_val.pop_front()});
                check("flags_out", {3'h0, flags_out}, {3'h0, flags_hold});
            end
        end
        prog_op_in <= prog_op[prog_addr];
        prog_operand <= prog_opd[prog_addr];
        prog_edge_slot <= prog_slot[prog_addr];
        data_bit <= mem[prog_opd[prog_addr]];
        retentive_bit <= mem[prog_opd[prog_addr]];
        if (cycles == MAX_CYC)
        begin
            miscompares++;
            stop_test();
        end
    end

    initial
    begin
        seed = 82;
        cycles = 0;
        miscompares = 0;
        samples_checked = 0;
        reset = 1'b1;
        run_mode = 1'b0;
        prog_op_in = OP_NOP;
        prog_operand = 8'h00;
        prog_edge_slot = 4'h0;
        retentive_bit = 1'b0;
        data_bit = 1'b0;
        flags_in = 5'h00;
        flags_hold = 5'h00;
        for (int i = 0; i < 256; i++)
        begin
            prog_op[i] = OP_NOP;
            prog_opd[i] = 8'h00;
            prog_slot[i] = 4'h0;
            mem[i] = 1'b0;
        end
        pulse_reset();
        run_mode = 1'b1;
        repeat (PD + 20) @(negedge clk);
        check("no_terminator", {7'h00, no_terminator}, 8'h01);
        check("running", {7'h00, running}, 8'h00);
        run_mode = 1'b0;
        plen = 3;
        add(OP_LOAD, 8'h00, 4'h0); add(OP_SERIES, 8'h01, 4'h0); add(OP_OUT, 8'h80, 4'h0);
        add(OP_LOAD_INV, 8'h00, 4'h0); add(OP_SERIES_INV, 8'h01, 4'h0); add(OP_OUT_INV, 8'h81, 4'h0);
        add(OP_LOAD, 8'h02, 4'h0); add(OP_PAR, 8'h03, 4'h0); add(OP_OUT, 8'h82, 4'h0);
        add(OP_LOAD, 8'h02, 4'h0); add(OP_PAR_INV, 8'h03, 4'h0); add(OP_OUT, 8'h83, 4'h0);
        add(OP_LOAD, 8'h00, 4'h0); add(OP_LOAD, 8'h01, 4'h0); add(OP_BLK_SERIES, 8'h00, 4'h0);
        add(OP_OUT, 8'h84, 4'h0);
        add(OP_LOAD, 8'h02, 4'h0); add(OP_LOAD, 8'h03, 4'h0); add(OP_BLK_PAR, 8'h00, 4'h0);
        add(OP_OUT, 8'h85, 4'h0);
        add(OP_LOAD, 8'h04, 4'h0); add(OP_RISE, 8'h86, 4'h0);
        add(OP_LOAD, 8'h04, 4'h0); add(OP_FALL, 8'h87, 4'h1);
        add(OP_LOAD, 8'h05, 4'h0); add(OP_LOAD, 8'h06, 4'h0); add(OP_LATCH, 8'hc0, 4'h0);
        add(OP_LOAD, 8'h07, 4'h0); add(OP_LOCK_BEGIN, 8'h00, 4'h0);
        add(OP_LOAD, 8'h04, 4'h0); add(OP_RISE, 8'h88, 4'hf);
        add(OP_LOAD, 8'h00, 4'h0); add(OP_OUT, 8'h89, 4'h0);
        add(OP_LOAD, 8'h05, 4'h0); add(OP_LOAD, 8'h06, 4'h0); add(OP_LATCH, 8'hc1, 4'h0);
        add(OP_LOCK_CLEAR, 8'h00, 4'h0); add(OP_NOP, 8'h00, 4'h0); add(OP_END, 8'h00, 4'h0);
        pulse_reset();
        new_inputs();
        model_scan();
        run_mode = 1'b1;
        wait_flag(1);
        check("no_terminator", {7'h00, no_terminator}, 8'h00);
        for (int scan = 0; scan < 40; scan++)
        begin
            wait_flag(0);
            if (scan == 20)
                pulse_reset();
            new_inputs();
            model_scan();
        end
        wait_flag(0);
        repeat (4) @(negedge clk);
        check("pending", exp_addr.size(), 8'h00);
        stop_test();
    end
endmodule : tb_ladder_bit_logic_executor
`default_nettype wire
